// ==== inc/pjch_pkg.sv ====
// Constants, field layouts and carrier types of the pipeline control block.
// Assumes a 16-bit instruction word and a 16-bit code address without segments.
package pjch_pkg;

	// ******************************************************************
	// Widths.
	// ******************************************************************
	localparam int PJCH_AW = 16;
	localparam int PJCH_DW = 16;
	localparam int PJCH_RW = 32;
	localparam int PJCH_BAW = 8;
	localparam int PJCH_NSFR = 11;
	localparam int PJCH_SIW = 4;

	// ******************************************************************
	// Core register indices.
	// ******************************************************************
	localparam logic [3:0] SFR_CP = 4'h0;
	localparam logic [3:0] SFR_DPP0 = 4'h1;
	localparam logic [3:0] SFR_SP = 4'h5;
	localparam logic [3:0] SFR_PSW = 4'h6;
	localparam logic [3:0] SFR_SYSCFG = 4'h7;
	localparam logic [3:0] SFR_BUSAREA = 4'h8;
	localparam logic [3:0] SFR_P3DIR = 4'h9;
	localparam logic [3:0] SFR_P3LATCH = 4'ha;
	localparam logic [15:0] SFR_RST = 16'h0000;

	// ******************************************************************
	// Status word fields, stack and program counter steps, program counter reset.
	// ******************************************************************
	localparam int PSW_IEN_BIT = 11;
	localparam int PSW_CPU_PRIORITY_LEVEL_LSB = 12;
	localparam int PSW_CPU_PRIORITY_LEVEL_W = 4;
	localparam logic [15:0] SP_STEP = 16'h0002;
	localparam logic [15:0] PC_STEP = 16'h0002;
	localparam logic [15:0] PC_RST = 16'h0000;

	// ******************************************************************
	// Software register map.
	// ******************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_HITS = 8'h08;
	localparam logic [7:0] REG_MISSES = 8'h0c;
	localparam logic [7:0] REG_SFR_BASE = 8'h40;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_INV_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;

	// ******************************************************************
	// Types.
	// ******************************************************************
	typedef enum logic [1:0] {BUS_NONE, BUS_WRITE, BUS_FETCH, BUS_READ} pjch_bus_e;

	typedef enum logic {FILL_IDLE, FILL_WAIT} pjch_fill_e;

	typedef struct packed {
		logic is_cache_jump;
		logic is_branch;
		logic taken;
		logic [15:0] target;
		logic csp_change;
		logic sfr_wr;
		logic [3:0] sfr_idx;
		logic sfr_rd;
		logic ext_read;
		logic ext_write;
		logic stack_pop;
		logic stack_push;
		logic [3:0] src_reg;
		logic [3:0] dst_reg;
		logic dst_wr;
	} pjch_dec_s;

	typedef struct packed {
		logic valid;
		logic injected;
		logic irq;
		logic [15:0] addr;
		logic [15:0] instr;
		logic [15:0] mem_addr;
		logic [15:0] data;
		pjch_dec_s info;
	} pjch_stage_s;

endpackage : pjch_pkg

// ==== design/pjch_pipe_ctrl.sv ====
// Four-stage pipeline control with a one-entry jump cache, core pointers and bus request priority.
// Assumes an outside decoder that turns the decode-stage word into pjch_dec_s in the same cycle.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module pjch_pipe_ctrl (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Software register port.
	input wire logic [pjch_pkg::PJCH_BAW-1:0] reg_addr,
	input wire logic [pjch_pkg::PJCH_RW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pjch_pkg::PJCH_RW-1:0] reg_rdata,
	// Decoder and datapath.
	output logic [pjch_pkg::PJCH_DW-1:0] dec_instr,
	output logic [pjch_pkg::PJCH_AW-1:0] dec_addr,
	output logic dec_valid,
	input wire pjch_pkg::pjch_dec_s dec_info,
	input wire logic [pjch_pkg::PJCH_AW-1:0] dec_mem_addr,
	input wire logic [pjch_pkg::PJCH_DW-1:0] ex_result,
	output logic fwd_from_ex,
	output logic fwd_from_wb,
	output logic [pjch_pkg::PJCH_NSFR*16-1:0] core_regs,
	output logic [pjch_pkg::PJCH_DW-1:0] rd_data,
	// External bus controller.
	output logic ebc_req,
	output pjch_pkg::pjch_bus_e ebc_kind,
	output logic [pjch_pkg::PJCH_AW-1:0] ebc_addr,
	output logic [pjch_pkg::PJCH_DW-1:0] ebc_wdata,
	input wire logic ebc_ready,
	input wire logic [pjch_pkg::PJCH_DW-1:0] ebc_rdata,
	// Interrupt request.
	input wire logic irq_req,
	input wire logic [pjch_pkg::PSW_CPU_PRIORITY_LEVEL_W-1:0] irq_level,
	input wire logic [pjch_pkg::PJCH_AW-1:0] irq_vector,
	output logic irq_ack,
	// Port 3.
	input wire logic [15:0] p3_pin,
	output logic [15:0] p3_out,
	output logic [15:0] p3_oe,
	output logic [15:0] p3_rmw_data
);
	import pjch_pkg::*;

	// ******************************************************************
	// State.
	// ******************************************************************
	pjch_stage_s fi_ff;
	pjch_stage_s dec_ff;
	pjch_stage_s ex_ff;
	pjch_stage_s wb_ff;
	logic [15:0] pc_ff;
	logic [15:0] sfr_ff [PJCH_NSFR];
	logic wr_done_ff;
	logic rd_done_ff;
	logic cache_valid_ff;
	logic [15:0] cache_tag_ff;
	logic [15:0] cache_instr_ff;
	logic [15:0] cache_taddr_ff;
	logic [15:0] fill_tag_ff;
	pjch_fill_e fill_ff;
	pjch_fill_e nxt_fill;
	logic ctrl_en_ff;
	logic [31:0] hits_ff;
	logic [31:0] misses_ff;
	logic [31:0] rdata_ff;
	logic [15:0] rd_data_ff;
	logic [15:0] pin_s1_ff;
	logic [15:0] pin_s2_ff;

	// ******************************************************************
	// Control terms.
	// ******************************************************************
	logic wr_pend;
	logic rd_pend;
	logic fet_req;
	logic fet_done;
	logic wr_gnt;
	logic rd_gnt;
	logic raw_stall;
	logic adv_back;
	logic adv_front;
	logic dec_live;
	logic redirect;
	logic hit;
	logic miss_fill;
	logic irq_take;
	logic invalidate;
	logic sw_inv;
	logic sp_hw;
	logic [15:0] nxt_sp_hw;
	logic byp;

	function automatic logic reg_match(input logic [3:0] a, input logic [3:0] b, input logic en);
		reg_match = en && (a == b);
	endfunction : reg_match

	assign dec_live = dec_ff.valid && !dec_ff.injected;
	assign wr_pend = wb_ff.valid && wb_ff.info.ext_write && !wr_done_ff;
	assign rd_pend = ex_ff.valid && ex_ff.info.ext_read && !rd_done_ff;
	assign raw_stall = dec_live && ex_ff.valid && reg_match(dec_info.sfr_idx, ex_ff.info.sfr_idx,
		dec_info.sfr_rd && ex_ff.info.sfr_wr);
	assign fet_req = !fi_ff.valid || (!raw_stall && !wr_pend && !rd_pend);
	assign wr_gnt = wr_pend;
	assign fet_done = fet_req && !wr_pend && ebc_ready;
	assign rd_gnt = rd_pend && !wr_pend && !fet_req;
	assign adv_back = (!wr_pend || (wr_gnt && ebc_ready)) && (!rd_pend || (rd_gnt && ebc_ready));
	assign adv_front = adv_back && !raw_stall;
	assign redirect = adv_front && dec_live && dec_info.is_branch && dec_info.taken;
	assign hit = redirect && dec_info.is_cache_jump && ctrl_en_ff && cache_valid_ff
		&& (cache_tag_ff == dec_ff.addr);
	assign miss_fill = redirect && dec_info.is_cache_jump && ctrl_en_ff && !hit;
	assign irq_take = adv_front && !redirect && !dec_ff.injected && irq_req
		&& sfr_ff[SFR_PSW][PSW_IEN_BIT]
		&& (irq_level > sfr_ff[SFR_PSW][PSW_CPU_PRIORITY_LEVEL_LSB +: PSW_CPU_PRIORITY_LEVEL_W]);
	assign sw_inv = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_INV_BIT];
	assign invalidate = irq_take || sw_inv || (adv_front && dec_live && dec_info.csp_change);
	assign irq_ack = irq_take;
	assign byp = fet_done && adv_front && !fi_ff.valid;

	// ******************************************************************
	// Bus request output.
	// ******************************************************************
	always_comb begin
		ebc_req = wr_pend || fet_req || rd_pend;
		ebc_kind = BUS_NONE;
		ebc_addr = pc_ff;
		ebc_wdata = wb_ff.data;
		if (wr_pend) begin
			ebc_kind = BUS_WRITE;
			ebc_addr = wb_ff.mem_addr;
		end else if (fet_req) begin
			ebc_kind = BUS_FETCH;
		end else if (rd_pend) begin
			ebc_kind = BUS_READ;
			ebc_addr = ex_ff.mem_addr;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_done_ff <= 1'b0;
			rd_done_ff <= 1'b0;
			rd_data_ff <= 16'h0000;
		end else begin
			wr_done_ff <= !adv_back && (wr_done_ff || (wr_gnt && ebc_ready));
			rd_done_ff <= !adv_back && (rd_done_ff || (rd_gnt && ebc_ready));
			if (rd_gnt && ebc_ready) begin
				rd_data_ff <= ebc_rdata;
			end
		end
	end

	// ******************************************************************
	// Fetch stage and program counter.
	// ******************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			fi_ff <= '0;
			pc_ff <= PC_RST;
		end else if (redirect || irq_take) begin
			fi_ff.valid <= 1'b0;
			if (irq_take) begin
				pc_ff <= irq_vector;
			end else if (hit) begin
				pc_ff <= 16'(cache_taddr_ff + PC_STEP);
			end else begin
				pc_ff <= dec_info.target;
			end
		end else if (fet_done) begin
			fi_ff <= '0;
			fi_ff.valid <= !byp;
			fi_ff.addr <= pc_ff;
			fi_ff.instr <= ebc_rdata;
			pc_ff <= 16'(pc_ff + PC_STEP);
		end else if (adv_front) begin
			fi_ff.valid <= 1'b0;
		end
	end

	// ******************************************************************
	// Decode, execute and write back stages.
	// ******************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			dec_ff <= '0;
		end else if (adv_front) begin
			dec_ff <= '0;
			if (hit) begin
				dec_ff.valid <= 1'b1;
				dec_ff.addr <= cache_taddr_ff;
				dec_ff.instr <= cache_instr_ff;
			end else if (redirect) begin
				dec_ff.valid <= 1'b1;
				dec_ff.injected <= 1'b1;
			end else if (irq_take) begin
				dec_ff.valid <= 1'b1;
				dec_ff.injected <= 1'b1;
				dec_ff.irq <= 1'b1;
			end else if (fi_ff.valid) begin
				dec_ff <= fi_ff;
			end else if (byp) begin
				dec_ff.valid <= 1'b1;
				dec_ff.addr <= pc_ff;
				dec_ff.instr <= ebc_rdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ex_ff <= '0;
		end else if (adv_front) begin
			ex_ff <= dec_ff;
			ex_ff.info <= dec_live ? dec_info : '0;
			ex_ff.mem_addr <= dec_mem_addr;
		end else if (adv_back) begin
			ex_ff <= '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ff <= '0;
		end else if (adv_back) begin
			wb_ff <= ex_ff;
			wb_ff.data <= ex_ff.info.ext_read ? rd_data_ff : ex_result;
		end
	end

	assign dec_instr = dec_ff.instr;
	assign dec_addr = dec_ff.addr;
	assign dec_valid = dec_live;
	assign rd_data = rd_data_ff;
	assign fwd_from_ex = dec_live && ex_ff.valid
		&& reg_match(dec_info.src_reg, ex_ff.info.dst_reg, ex_ff.info.dst_wr);
	assign fwd_from_wb = dec_live && wb_ff.valid
		&& reg_match(dec_info.src_reg, wb_ff.info.dst_reg, wb_ff.info.dst_wr);

	// ******************************************************************
	// Jump cache.
	// ******************************************************************
	always_comb begin
		nxt_fill = fill_ff;
		case (fill_ff)
			FILL_IDLE: begin
				if (miss_fill) begin
					nxt_fill = FILL_WAIT;
				end
			end
			FILL_WAIT: begin
				if (invalidate || redirect || fet_done) begin
					nxt_fill = miss_fill ? FILL_WAIT : FILL_IDLE;
				end
			end
			default: nxt_fill = FILL_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fill_ff <= FILL_IDLE;
			fill_tag_ff <= 16'h0000;
			cache_valid_ff <= 1'b0;
			cache_tag_ff <= 16'h0000;
			cache_instr_ff <= 16'h0000;
			cache_taddr_ff <= 16'h0000;
		end else begin
			fill_ff <= nxt_fill;
			if (miss_fill) begin
				fill_tag_ff <= dec_ff.addr;
			end
			if (invalidate) begin
				cache_valid_ff <= 1'b0;
			end else if (fill_ff == FILL_WAIT && fet_done && !redirect) begin
				cache_valid_ff <= 1'b1;
				cache_tag_ff <= fill_tag_ff;
				cache_instr_ff <= ebc_rdata;
				cache_taddr_ff <= pc_ff;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hits_ff <= 32'h00000000;
			misses_ff <= 32'h00000000;
		end else begin
			if (hit) begin
				hits_ff <= 32'(hits_ff + 32'h00000001);
			end
			if (miss_fill) begin
				misses_ff <= 32'(misses_ff + 32'h00000001);
			end
		end
	end

	// ******************************************************************
	// Core pointers, written by execute whenever the back end advances; stack pointer also stepped from decode.
	// ******************************************************************
	assign sp_hw = adv_front && dec_live && (dec_info.stack_pop || dec_info.stack_push);
	assign nxt_sp_hw = dec_info.stack_push ? 16'(sfr_ff[SFR_SP] - SP_STEP) : 16'(sfr_ff[SFR_SP] + SP_STEP);

	generate
		for (genvar gi = 0; gi < PJCH_NSFR; gi++) begin : g_sfr
			always_ff @(posedge clk) begin
				if (rst) begin
					sfr_ff[gi] <= SFR_RST;
				end else if (adv_back && ex_ff.valid && !ex_ff.injected && ex_ff.info.sfr_wr
					&& (ex_ff.info.sfr_idx == 4'(gi))) begin
					sfr_ff[gi] <= ex_result;
				end else if (gi == int'(SFR_SP) && sp_hw) begin
					sfr_ff[gi] <= nxt_sp_hw;
				end
			end
			assign core_regs[gi*16 +: 16] = sfr_ff[gi];
		end
	endgenerate

	// ******************************************************************
	// Port 3.
	// ******************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1_ff <= 16'h0000;
			pin_s2_ff <= 16'h0000;
		end else begin
			pin_s1_ff <= p3_pin;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign p3_out = sfr_ff[SFR_P3LATCH];
	assign p3_oe = sfr_ff[SFR_P3DIR];
	assign p3_rmw_data = (sfr_ff[SFR_P3DIR] & sfr_ff[SFR_P3LATCH]) | (~sfr_ff[SFR_P3DIR] & pin_s2_ff);

	// ******************************************************************
	// Software register port.
	// ******************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_en_ff <= CTRL_EN_RST;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			ctrl_en_ff <= reg_wdata[CTRL_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 32'h00000000;
		end else if (reg_rd) begin
			rdata_ff <= 32'h00000000;
			if (reg_addr == REG_CTRL) begin
				rdata_ff <= {31'h00000000, ctrl_en_ff};
			end else if (reg_addr == REG_STATUS) begin
				rdata_ff <= {cache_tag_ff, 14'h0000, fill_ff == FILL_WAIT, cache_valid_ff};
			end else if (reg_addr == REG_HITS) begin
				rdata_ff <= hits_ff;
			end else if (reg_addr == REG_MISSES) begin
				rdata_ff <= misses_ff;
			end else if (reg_addr >= REG_SFR_BASE && reg_addr < 8'(REG_SFR_BASE + 8'(4 * PJCH_NSFR))
				&& reg_addr[1:0] == 2'h0) begin
				rdata_ff <= {16'h0000, sfr_ff[4'(8'(reg_addr - REG_SFR_BASE) >> 2)]};
			end
		end else begin
			rdata_ff <= 32'h00000000;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule : pjch_pipe_ctrl

// ==== sim/pjch_bus_model.sv ====
// Far side model: external bus controller with a small program and data memory.
// Assumes the bench fills mem just before each reset, or right after it, and picks prompt or slow answers.
`timescale 1ns/1ns
module pjch_bus_model (
	// Clock, reset and answer speed.
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	// Bus port.
	input wire logic ebc_req,
	input wire pjch_pkg::pjch_bus_e ebc_kind,
	input wire logic [15:0] ebc_addr,
	input wire logic [15:0] ebc_wdata,
	output logic ebc_ready,
	output logic [15:0] ebc_rdata
);
	import pjch_pkg::*;
	logic [15:0] mem [0:255];
	logic [1:0] wait_ff;
	logic [15:0] junk_ff;
	// *****************************************
	// Serves the shown request after 0 to 2 idle cycles.
	// *****************************************
	always @(posedge clk) begin
		if (rst || !ebc_req || ebc_ready) begin
			wait_ff <= slow ? 2'($urandom_range(2)) : 2'h0;
		end else begin
			wait_ff <= wait_ff - 2'h1;
		end
		junk_ff <= rst ? 16'h5a5a : ~junk_ff;
		if (ebc_ready && ebc_kind == BUS_WRITE) begin
			mem[ebc_addr[8:1]] <= ebc_wdata;
		end
	end
	assign ebc_ready = ebc_req && wait_ff == 2'h0;
	assign ebc_rdata = ebc_ready ? mem[ebc_addr[8:1]] : junk_ff;
endmodule : pjch_bus_model

// ==== sim/pjch_pipe_chk.sv ====
// Port checker of the pipeline control block.
// Assumes it is bound to every instance of pjch_pipe_ctrl.
`timescale 1ns/1ns
module pjch_pipe_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Watched ports.
	input wire logic reg_rd,
	input wire logic [pjch_pkg::PJCH_RW-1:0] reg_rdata,
	input wire logic dec_valid,
	input wire logic [pjch_pkg::PJCH_AW-1:0] dec_addr,
	input wire pjch_pkg::pjch_dec_s dec_info,
	input wire logic [pjch_pkg::PJCH_NSFR*16-1:0] core_regs,
	input wire logic ebc_req,
	input wire pjch_pkg::pjch_bus_e ebc_kind,
	input wire logic [pjch_pkg::PJCH_AW-1:0] ebc_addr,
	input wire logic ebc_ready,
	input wire logic irq_req,
	input wire logic [15:0] p3_pin,
	input wire logic [15:0] p3_out,
	input wire logic [15:0] p3_oe,
	input wire logic [15:0] p3_rmw_data
);
	import pjch_pkg::*;
	logic [15:0] tgt_ff;
	logic [1:0] age_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk) begin
		if (rst) begin
			age_ff <= 2'h0;
		end else if (age_ff != 2'h3) begin
			age_ff <= age_ff + 2'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (dec_valid && dec_info.taken) begin
			tgt_ff <= dec_info.target;
		end
	end
	// *****************************************
	// Assertions.
	// *****************************************
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its answer cycle");
	a_reset_fetch: assert property ($past(rst) |-> ebc_req && ebc_kind == BUS_FETCH && ebc_addr == PC_RST)
		else $error("no first fetch after reset");
	a_write_first: assert property (ebc_req && ebc_kind == BUS_WRITE && !ebc_ready |=>
		ebc_req && ebc_kind == BUS_WRITE && $stable(ebc_addr)) else $error("pending write displaced");
	a_fetch_over_read: assert property (ebc_req && ebc_kind == BUS_FETCH && !ebc_ready |=>
		ebc_req && ebc_kind != BUS_READ) else $error("read shown over pending fetch");
	a_branch_bubble: assert property (dec_valid && dec_info.taken && !dec_info.is_cache_jump && !irq_req
		|=> !dec_valid || $stable(dec_addr)) else $error("no bubble after taken branch");
	a_target_reach: assert property (dec_valid && dec_info.taken && !irq_req |=> ##[0:12] dec_addr == tgt_ff)
		else $error("branch target not decoded");
	a_oe_dir: assert property (p3_oe == core_regs[SFR_P3DIR*16 +: 16])
		else $error("port direction differs from its register");
	a_latch_out: assert property (p3_out == core_regs[SFR_P3LATCH*16 +: 16])
		else $error("port output differs from its latch");
	a_port_rmw: assert property (age_ff == 2'h3 |-> p3_rmw_data == ((p3_out & p3_oe) | ($past(p3_pin, 2) & ~p3_oe)))
		else $error("port read mixes pins and latch wrongly");
endmodule : pjch_pipe_chk

bind pjch_pipe_ctrl pjch_pipe_chk u_chk (
	.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dec_valid(dec_valid), .dec_addr(dec_addr),
	.dec_info(dec_info), .core_regs(core_regs), .ebc_req(ebc_req), .ebc_kind(ebc_kind), .ebc_addr(ebc_addr),
	.ebc_ready(ebc_ready), .irq_req(irq_req), .p3_pin(p3_pin), .p3_out(p3_out), .p3_oe(p3_oe),
	.p3_rmw_data(p3_rmw_data)
);

// ==== sim/pipeline_jump_cache_hazards_bench.sv ====
// Self-checking bench of the pipeline control block.
// Assumes the package, design, checker and bus model are compiled before it.
`timescale 1ns/1ns
module pipeline_jump_cache_hazards_bench;
	import pjch_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic slow = 1'b0;
	logic irq_req = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [15:0] ex_result = 16'h0;
	logic [15:0] p3_pin = 16'h0;
	logic [15:0] dec_instr, dec_addr, ebc_addr, ebc_wdata, ebc_rdata, rd_data, p3_out, p3_oe, p3_rmw_data;
	logic dec_valid, ebc_req, ebc_ready, irq_ack, fwd_ex, fwd_wb;
	logic [PJCH_NSFR*16-1:0] core_regs;
	pjch_dec_s dec_info;
	pjch_bus_e ebc_kind;
	int bad_count = 0;
	int n_tests = 0;
	always #5 clk = ~clk;
	always @(posedge clk) p3_pin <= 16'($urandom);
	// *****************************************
	// Decoder: op in [15:12], target or index below.
	// *****************************************
	always_comb begin
		dec_info = '0;
		dec_info.target = {4'h0, dec_instr[11:0]};
		dec_info.is_cache_jump = dec_valid && dec_instr[15:12] == 4'h1;
		dec_info.csp_change = dec_valid && dec_instr[15:12] == 4'h4;
		dec_info.is_branch = dec_info.is_cache_jump || dec_info.csp_change || (dec_valid && dec_instr[15:12] == 4'h2);
		dec_info.taken = dec_info.is_branch;
		dec_info.sfr_wr = dec_valid && dec_instr[15:12] == 4'h3;
		dec_info.sfr_idx = dec_instr[3:0];
		dec_info.ext_write = dec_valid && dec_instr[15:12] == 4'h5;
		dec_info.ext_read = dec_valid && dec_instr[15:12] == 4'h6;
		dec_info.src_reg = dec_instr[7:4];
		dec_info.dst_reg = dec_instr[3:0];
		dec_info.dst_wr = dec_info.sfr_wr;
	end
	pjch_pipe_ctrl dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .dec_instr(dec_instr), .dec_addr(dec_addr), .dec_valid(dec_valid),
		.dec_info(dec_info), .dec_mem_addr({4'h0, dec_instr[11:0]}), .ex_result(ex_result), .fwd_from_ex(fwd_ex),
		.fwd_from_wb(fwd_wb), .core_regs(core_regs), .rd_data(rd_data), .ebc_req(ebc_req), .ebc_kind(ebc_kind),
		.ebc_addr(ebc_addr), .ebc_wdata(ebc_wdata), .ebc_ready(ebc_ready), .ebc_rdata(ebc_rdata),
		.irq_req(irq_req), .irq_level(4'h5), .irq_vector(16'h0100), .irq_ack(irq_ack), .p3_pin(p3_pin),
		.p3_out(p3_out), .p3_oe(p3_oe), .p3_rmw_data(p3_rmw_data)
	);
	pjch_bus_model mdl (
		.clk(clk), .rst(rst), .slow(slow), .ebc_req(ebc_req), .ebc_kind(ebc_kind), .ebc_addr(ebc_addr),
		.ebc_wdata(ebc_wdata), .ebc_ready(ebc_ready), .ebc_rdata(ebc_rdata)
	);
	// *****************************************
	// Shared tasks.
	// *****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : reg_read
	task automatic start(input logic [15:0] w0, w1, w2, input logic [15:0] res, input logic s);
		for (int i = 0; i < 256; i++) mdl.mem[i] = 16'h0;
		mdl.mem[0] = w0;
		mdl.mem[1] = w1;
		mdl.mem[2] = w2;
		mdl.mem[8'h80] = 16'h2100;
		@(posedge clk);
		rst <= 1'b1;
		ex_result <= res;
		slow <= s;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
	endtask : start
	task automatic run_loop(input logic [15:0] w0, w1, w2, meas, input logic en, input int first, later);
		int t [4];
		int n;
		n = 0;
		start(w0, w1, w2, 16'h0, 1'b0);
		reg_write(REG_CTRL, {31'h0, en});
		for (int c = 0; c < 300 && n < 4; c++) begin
			@(posedge clk);
			#1;
			if (dec_valid === 1'b1 && dec_addr === meas) begin
				t[n] = c;
				n++;
			end
		end
		check(n, 4);
		check(t[1] - t[0], first);
		check(t[3] - t[2], later);
		$display("loop test done at %0t", $time);
	endtask : run_loop
	task automatic run_sfr();
		logic [15:0] v;
		int k;
		v = 16'($urandom);
		start(16'h3000, 16'h3001, 16'h3002, v, 1'b1);
		for (int i = 3; i < 11; i++) mdl.mem[i] = 16'h3000 | 16'(i);
		mdl.mem[11] = 16'h51f0;
		mdl.mem[12] = 16'h61f0;
		mdl.mem[13] = 16'h201a;
		reg_read(REG_CTRL, 32'h1);
		reg_read(REG_HITS, 32'h0);
		reg_read(8'h20, 32'h0);
		for (k = 0; k < 200 && dec_addr !== 16'h001a; k++) @(posedge clk);
		repeat (4) @(posedge clk);
		reg_write(REG_SFR_BASE, 32'h0);
		for (int i = 0; i < 11; i++) reg_read(REG_SFR_BASE + 8'(4 * i), {16'h0, v});
		check(p3_oe, v);
		check(p3_out, v);
		check(mdl.mem[8'hf8], v);
		check(rd_data, v);
		$display("register test done at %0t", $time);
	endtask : run_sfr
	task automatic run_irq(input logic [15:0] processor_status_word, input logic exp);
		logic seen;
		logic went;
		seen = 1'b0;
		went = 1'b0;
		start(16'h3006, 16'h2002, 16'h0, processor_status_word, 1'b1);
		irq_req <= 1'b1;
		for (int c = 0; c < 60; c++) begin
			@(posedge clk);
			if (seen) irq_req <= 1'b0;
			#1;
			if (irq_ack === 1'b1) seen = 1'b1;
			if (dec_addr === 16'h0100) went = 1'b1;
		end
		@(posedge clk);
		irq_req <= 1'b0;
		check(seen, exp);
		check(went, exp);
		$display("interrupt test done at %0t", $time);
	endtask : run_irq
	task automatic run_fwd();
		start(16'h3000, 16'h3005, 16'h2000, 16'h0, 1'b0);
		@(posedge clk);
		#1 check(fwd_ex, 1'b0);
		@(posedge clk);
		#1 check(fwd_ex, 1'b1);
		check(fwd_wb, 1'b0);
		@(posedge clk);
		#1 check(fwd_ex, 1'b0);
		check(fwd_wb, 1'b1);
		$display("forwarding test done at %0t", $time);
	endtask : run_fwd
	task automatic final_report();
		$display("Summary: %0d checks, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	// *****************************************
	// Main sequence and watchdog.
	// *****************************************
	initial begin
		void'($urandom(2288));
		run_loop(16'h0000, 16'h0000, 16'h1000, 16'h0004, 1'b1, 4, 3);
		run_loop(16'h0000, 16'h0000, 16'h2000, 16'h0004, 1'b1, 4, 4);
		run_loop(16'h1004, 16'h0000, 16'h4000, 16'h0000, 1'b1, 4, 4);
		run_loop(16'h0000, 16'h0000, 16'h1000, 16'h0004, 1'b0, 4, 4);
		run_sfr();
		run_fwd();
		run_irq(16'h0800, 1'b1);
		run_irq(16'h0000, 1'b0);
		run_irq(16'hf800, 1'b0);
		final_report();
	end
	initial begin
		#1000000;
		bad_count++;
		final_report();
	end
endmodule : pipeline_jump_cache_hazards_bench
